// ==== hdl/fwg_defines.svh ====
/*
  Offsets, field positions, widths and reset values of the flash window
  and debug id guard.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef FWG_DEFINES_SVH
`define FWG_DEFINES_SVH

// ======================================================================
// widths
`define FWG_ADDR_W        8
`define FWG_DATA_W        32
`define FWG_BLK_W         16
`define FWG_ID_W          128
`define FWG_ENG_N         6
`define FWG_ID_WORDS      4

// ======================================================================
// register byte offsets
`define FWG_OFS_CTRL      8'h00
`define FWG_OFS_STG_START 8'h04
`define FWG_OFS_STG_END   8'h08
`define FWG_OFS_WIN_START 8'h0c
`define FWG_OFS_WIN_END   8'h10
`define FWG_OFS_STATUS    8'h14
`define FWG_OFS_ID0       8'h20
`define FWG_OFS_ID1       8'h24
`define FWG_OFS_ID2       8'h28
`define FWG_OFS_ID3       8'h2c

// ======================================================================
// control command bits (write one to fire)
`define FWG_CTRL_SET      0
`define FWG_CTRL_CLR      1
`define FWG_CTRL_LOCK     2
`define FWG_CTRL_ERASE    3

// ======================================================================
// status bits
`define FWG_ST_LOCKBIT    0
`define FWG_ST_BUSY       1
`define FWG_ST_REFUSED    2
`define FWG_ST_ACCEPTED   3
`define FWG_ST_REJECTED   4

// ======================================================================
// id code fields and reset values
`define FWG_ID_ENABLE_BIT 127
`define FWG_ID_ERASE_BIT  126
`define FWG_ID_ERASED     128'hffffffff_ffffffff_ffffffff_ffffffff
`define FWG_LOCK_OPEN     1'b1
`define FWG_BLK_ZERO      16'h0000

`endif

// ==== hdl/fwg_pkg.sv ====
/*
  Types shared by the flash window and debug id guard.
  Assumes nothing of its surroundings.
*/
package fwg_pkg;

  // ======================================================================
  // debug / factory connection handling states
  typedef enum logic [1:0] {
    FWG_IDLE,
    FWG_CHECK,
    FWG_ERASE,
    FWG_HOLD
  } fwg_conn_e;

endpackage

// ==== hdl/fwg_sync.sv ====
/*
  Two-flop level synchroniser of parameterised width.
  Assumes each bit is a level that stays put long enough to be caught;
  a multi-bit word must be stable before its qualifier is raised.
*/
`timescale 1ns/1ns
module fwg_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ======================================================================
  // first stage is read only by the second stage
  logic [W-1:0] meta;

  // plain two-stage chain, synchronous reset to zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== hdl/fwg_guard.sv ====
/*
  Flash access window and debug id guard: an apb register slave that holds
  the programmable window, its one-way lock, and the 128-bit id code, checks
  flash program/erase requests against the window and judges debugger or
  boot programmer connections against the id code.
  Assumes engine_en, sguard_en and op_* come from logic on ref_clk; the
  dbg_* pins come from outside and are synchronised here. The tool holds
  dbg_id and dbg_factory stable before raising dbg_conn_req.
*/
// Contract
// - config writes refused while any transfer, panel, drawing or codec engine runs
// - window spans blocks from start up to but not including end
// - program or erase outside the window is blocked for every requester
// - after locking, setting new start and end leaves window unchanged
// - window clear writes zero to start and end, disabling window control
// - clear acts only before the lock is applied
// - clearing the lock bit makes the window setting permanent; here rst_n sets lock_bit open again and zeroes the window
// - after locking, flash outside the window becomes write-once
// - connecting tool presents an id compared with the stored 128-bit code
// - serial and usb boot programming use the same id check
// - id bit 127 zero rejects every debug and factory connection
// - bit 126 one: accept on match, factory mode entry erases flash
// - bit 126 zero: accept on match without erasing flash
// - no factory erase once the window is permanently locked
// - secure region guard enabled makes factory bootloader unavailable
// - full flash erase returns the id code to all ones
`timescale 1ns/1ns
`include "fwg_defines.svh"
module fwg_guard
  import fwg_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`FWG_ADDR_W-1:0]  paddr,
  input  wire logic [`FWG_DATA_W-1:0]  pwdata,
  output logic      [`FWG_DATA_W-1:0]  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [`FWG_ENG_N-1:0]   engine_en,
  input  wire logic                    sguard_en,
  input  wire logic                    op_req,
  input  wire logic [`FWG_BLK_W-1:0]   op_blk,
  output logic                         op_grant,
  output logic                         op_deny,
  input  wire logic                    dbg_conn_req,
  input  wire logic                    dbg_factory,
  input  wire logic [`FWG_ID_W-1:0]    dbg_id,
  output logic                         conn_accept,
  output logic                         conn_reject,
  output logic                         flash_erase_req
);

  // ======================================================================
  // state
  logic [`FWG_BLK_W-1:0]  stg_start;
  logic [`FWG_BLK_W-1:0]  stg_end;
  logic [`FWG_BLK_W-1:0]  win_start;
  logic [`FWG_BLK_W-1:0]  win_end;
  logic                   lock_bit;
  logic [`FWG_ID_W-1:0]   id_code;
  logic                   refused;
  logic                   acc_seen;
  logic                   rej_seen;
  logic                   cfg_block;
  logic                   req_prev;
  fwg_conn_e              st;
  logic [`FWG_ID_W+1:0]   sync_q;

  // ======================================================================
  // apb decode
  wire                    apb_setup  = psel & ~penable;
  wire                    apb_access = psel & penable & pready;
  wire                    apb_wr     = apb_access & pwrite;
  wire                    hit_ctrl   = (paddr == `FWG_OFS_CTRL);
  wire                    hit_stg_s  = (paddr == `FWG_OFS_STG_START);
  wire                    hit_stg_e  = (paddr == `FWG_OFS_STG_END);
  wire                    hit_win_s  = (paddr == `FWG_OFS_WIN_START);
  wire                    hit_win_e  = (paddr == `FWG_OFS_WIN_END);
  wire                    hit_status = (paddr == `FWG_OFS_STATUS);
  wire [`FWG_ID_WORDS-1:0] hit_id    = {paddr == `FWG_OFS_ID3, paddr == `FWG_OFS_ID2,
                                        paddr == `FWG_OFS_ID1, paddr == `FWG_OFS_ID0};
  wire                    mapped     = hit_ctrl | hit_stg_s | hit_stg_e | hit_win_s
                                     | hit_win_e | hit_status | (|hit_id);
  // control and id words live in configuration memory
  wire                    cfg_target = hit_ctrl | (|hit_id);
  wire                    cfg_busy   = |engine_en;
  wire                    next_block = pwrite & cfg_target & cfg_busy;
  wire                    next_err   = ~mapped | next_block;

  // ======================================================================
  // read mux, sampled in the setup phase so prdata is a flop
  wire [`FWG_DATA_W-1:0]  rd_status  = {{(`FWG_DATA_W-5){1'b0}}, rej_seen, acc_seen,
                                        refused, cfg_busy, lock_bit};
  wire [`FWG_DATA_W-1:0]  rd_id      = hit_id[3] ? id_code[3*`FWG_DATA_W +: `FWG_DATA_W] :
                                       hit_id[2] ? id_code[2*`FWG_DATA_W +: `FWG_DATA_W] :
                                       hit_id[1] ? id_code[`FWG_DATA_W +: `FWG_DATA_W] : id_code[`FWG_DATA_W-1:0];
  wire [`FWG_DATA_W-1:0]  next_rdata = hit_stg_s  ? {16'h0000, stg_start} :
                                       hit_stg_e  ? {16'h0000, stg_end} :
                                       hit_win_s  ? {16'h0000, win_start} :
                                       hit_win_e  ? {16'h0000, win_end} :
                                       hit_status ? rd_status :
                                       (|hit_id)  ? rd_id : 32'h0000_0000;

  // ======================================================================
  // command decode: the busy verdict was frozen at setup
  wire                    cfg_wr_ok  = apb_wr & ~cfg_block;
  wire                    ctrl_wr    = cfg_wr_ok & hit_ctrl;
  wire                    set_fire   = ctrl_wr & pwdata[`FWG_CTRL_SET] & lock_bit;
  wire                    clr_fire   = ctrl_wr & pwdata[`FWG_CTRL_CLR] & lock_bit;
  wire                    lock_fire  = ctrl_wr & pwdata[`FWG_CTRL_LOCK];
  // a full erase would wipe the write-once area, so locking forbids it
  wire                    sw_erase   = ctrl_wr & pwdata[`FWG_CTRL_ERASE] & lock_bit;
  wire                    lock_try   = ctrl_wr & ~lock_bit & (pwdata[`FWG_CTRL_SET]
                                     | pwdata[`FWG_CTRL_CLR] | pwdata[`FWG_CTRL_ERASE]);
  wire                    refuse_ev  = (apb_wr & cfg_target & cfg_block) | lock_try;

  // ======================================================================
  // window next values; clear beats set when both are written
  wire [`FWG_BLK_W-1:0]   next_win_start = clr_fire ? `FWG_BLK_ZERO :
                                           set_fire ? stg_start : win_start;
  wire [`FWG_BLK_W-1:0]   next_win_end   = clr_fire ? `FWG_BLK_ZERO :
                                           set_fire ? stg_end : win_end;

  // ======================================================================
  // flash operation check
  wire                    win_off    = (win_start == `FWG_BLK_ZERO) & (win_end == `FWG_BLK_ZERO);
  wire                    in_win     = win_off | ((op_blk >= win_start) & (op_blk < win_end));

  // ======================================================================
  // connection judgement on synchronised pins
  wire [`FWG_ID_W-1:0]    id_s       = sync_q[`FWG_ID_W-1:0];
  wire                    factory_s  = sync_q[`FWG_ID_W];
  wire                    conn_s     = sync_q[`FWG_ID_W+1];
  wire                    req_rise   = conn_s & ~req_prev;
  wire                    id_match   = (id_s == id_code);
  wire                    deny       = ~id_code[`FWG_ID_ENABLE_BIT]
                                     | ~id_match
                                     | (factory_s & sguard_en);
  // erase only in the erasing mode and only while the window is unlocked
  wire                    want_erase = factory_s & id_code[`FWG_ID_ERASE_BIT] & lock_bit;
  wire                    erase_fire = (st == FWG_ERASE) | sw_erase;

  fwg_conn_e              next_st;
  always_comb begin
    next_st = st;
    case (st)
      FWG_IDLE:  if (req_rise) next_st = FWG_CHECK;
      FWG_CHECK: next_st = (!deny && want_erase) ? FWG_ERASE : FWG_HOLD;
      FWG_ERASE: next_st = FWG_HOLD;
      FWG_HOLD:  if (!conn_s) next_st = FWG_IDLE;
      default:   next_st = FWG_IDLE;
    endcase
  end

  // ======================================================================
  // pin synchroniser for the external tool
  fwg_sync #(
    .W (`FWG_ID_W + 2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({dbg_conn_req, dbg_factory, dbg_id}),
    .q       (sync_q)
  );

  // apb answer flops: zero wait states
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      cfg_block <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata    <= next_rdata;
        pslverr   <= next_err;
        cfg_block <= next_block;
      end else if (apb_access) begin
        pslverr   <= 1'b0;
        cfg_block <= 1'b0;
      end
    end
  end

  // staging registers, free to write at any time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stg_start <= `FWG_BLK_ZERO;
      stg_end   <= `FWG_BLK_ZERO;
    end else begin
      if (apb_wr && hit_stg_s) stg_start <= pwdata[`FWG_BLK_W-1:0];
      if (apb_wr && hit_stg_e) stg_end   <= pwdata[`FWG_BLK_W-1:0];
    end
  end

  // window and lock; the lock only ever falls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      win_start <= `FWG_BLK_ZERO;
      win_end   <= `FWG_BLK_ZERO;
      lock_bit  <= `FWG_LOCK_OPEN;
    end else begin
      win_start <= next_win_start;
      win_end   <= next_win_end;
      if (lock_fire) lock_bit <= 1'b0;
    end
  end

  // id code words; erase wins over a word write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      id_code <= `FWG_ID_ERASED;
    end else if (erase_fire) begin
      id_code <= `FWG_ID_ERASED;
    end else begin
      for (int i = 0; i < `FWG_ID_WORDS; i++) begin
        if (cfg_wr_ok && hit_id[i]) id_code[i*`FWG_DATA_W +: `FWG_DATA_W] <= pwdata;
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refused  <= 1'b0;
      acc_seen <= 1'b0;
      rej_seen <= 1'b0;
    end else begin
      refused  <= refuse_ev | (refused & ~(apb_wr & hit_status & pwdata[`FWG_ST_REFUSED]));
      acc_seen <= (st == FWG_CHECK && !deny)
                | (acc_seen & ~(apb_wr & hit_status & pwdata[`FWG_ST_ACCEPTED]));
      rej_seen <= (st == FWG_CHECK && deny)
                | (rej_seen & ~(apb_wr & hit_status & pwdata[`FWG_ST_REJECTED]));
    end
  end

  // flash request verdict, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_grant <= 1'b0;
      op_deny  <= 1'b0;
    end else begin
      op_grant <= op_req & in_win;
      op_deny  <= op_req & ~in_win;
    end
  end

  // connection state machine and its outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st              <= FWG_IDLE;
      req_prev        <= 1'b0;
      conn_accept     <= 1'b0;
      conn_reject     <= 1'b0;
      flash_erase_req <= 1'b0;
    end else begin
      st              <= next_st;
      req_prev        <= conn_s;
      flash_erase_req <= erase_fire;
      if (st == FWG_CHECK && deny) conn_reject <= 1'b1;
      if (st == FWG_CHECK && !deny && !want_erase) conn_accept <= 1'b1;
      if (st == FWG_ERASE) conn_accept <= 1'b1;
      if (st == FWG_HOLD && !conn_s) begin
        conn_accept <= 1'b0;
        conn_reject <= 1'b0;
      end
    end
  end

  // ======================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_REFUSE_BUSY: assert property (
    apb_wr && cfg_target && cfg_block |=> $stable(win_start) && $stable(win_end) && $stable(lock_bit)
  ) else $error("config write taken while an engine was enabled");

  AST_GRANT_INSIDE: assert property (
    op_req && op_blk >= win_start && op_blk < win_end |=> op_grant && !op_deny
  ) else $error("request inside window not granted");

  AST_DENY_OUTSIDE: assert property (
    op_req && !win_off && (op_blk < win_start || op_blk >= win_end) |=> op_deny && !op_grant
  ) else $error("request outside window not denied");

  AST_LOCKED_FROZEN: assert property (
    !lock_bit |=> !lock_bit && $stable(win_start) && $stable(win_end)
  ) else $error("locked window changed");

  AST_CLEAR_ZERO: assert property (
    ctrl_wr && pwdata[`FWG_CTRL_CLR] && lock_bit |=> win_start == `FWG_BLK_ZERO && win_end == `FWG_BLK_ZERO
  ) else $error("clear did not zero the window");

  AST_ID_DISABLED: assert property (
    st == FWG_CHECK && !id_code[`FWG_ID_ENABLE_BIT] |=> conn_reject && !conn_accept ##1 !flash_erase_req
  ) else $error("connection not rejected with id bit 127 clear");

  AST_MISMATCH: assert property (
    st == FWG_CHECK && id_s != id_code |=> conn_reject ##1 !flash_erase_req [*2]
  ) else $error("mismatched id not rejected or flash touched");

  AST_ERASE_ON_MATCH: assert property (
    st == FWG_CHECK && !deny && factory_s && id_code[`FWG_ID_ERASE_BIT] && lock_bit
    |-> ##2 flash_erase_req && conn_accept && id_code == `FWG_ID_ERASED
  ) else $error("factory entry in erase mode did not erase");

  AST_NO_ERASE_PLAIN: assert property (
    st == FWG_CHECK && !deny && !id_code[`FWG_ID_ERASE_BIT] |=> conn_accept ##1 !flash_erase_req
  ) else $error("match without erase mode misbehaved");

  AST_NO_ERASE_LOCKED: assert property (
    !lock_bit && st != FWG_ERASE |=> !flash_erase_req
  ) else $error("flash erase issued while window locked");

  AST_FACTORY_GUARD: assert property (
    st == FWG_CHECK && factory_s && sguard_en |=> conn_reject
  ) else $error("factory connection accepted with secure guard on");

  AST_CLEAR_LOCKED: assert property (
    ctrl_wr && pwdata[`FWG_CTRL_CLR] && !lock_bit |=> refused && $stable(win_start) && $stable(win_end)
  ) else $error("clear acted on a locked window");

  AST_REFUSE_ID: assert property (
    apb_wr && (|hit_id) && cfg_block && st != FWG_ERASE |=> $stable(id_code)
  ) else $error("id word written while an engine was enabled");

  AST_ERASE_ONES: assert property (
    erase_fire |=> flash_erase_req && id_code == `FWG_ID_ERASED
  ) else $error("erase did not restore the id code");

  AST_ACCEPT_MATCH: assert property (
    st == FWG_CHECK && id_match && id_code[`FWG_ID_ENABLE_BIT] && !(factory_s && sguard_en)
    |-> ##[1:2] conn_accept && !conn_reject
  ) else $error("matching id not accepted");

  COV_ACCEPT_ERASE: cover property (st == FWG_ERASE ##1 flash_erase_req);
  COV_REJECT:       cover property (st == FWG_CHECK && deny ##1 conn_reject);
  COV_LOCK:         cover property ($fell(lock_bit));
  COV_REFUSED:      cover property (apb_wr && cfg_target && cfg_block);

endmodule

// ==== testbench/fwg_tool_model.sv ====
/*
  Behavioural model of the external debugger or serial/usb boot programmer.
  Assumes the bench calls connect from its main sequence, after a clock edge.
*/
`timescale 1ns/1ns
module fwg_tool_model (
  input  wire logic         ref_clk,
  input  wire logic         conn_accept,
  input  wire logic         conn_reject,
  output logic              dbg_conn_req,
  output logic              dbg_factory,
  output logic [127:0]      dbg_id
);
  // ======================================================================
  // idle pins at time zero
  initial begin
    dbg_conn_req = 1'b0;
    dbg_factory  = 1'b0;
    dbg_id       = 128'h0;
  end

  // ======================================================================
  // one connection; id and mode settle before the request rises
  task automatic connect(input logic [127:0] id, input logic fac, input int lag,
                         output logic acc, output logic rej);
    int n;
    n = 0;
    @(posedge ref_clk);
    dbg_id      <= id;
    dbg_factory <= fac;
    repeat (lag + 1) @(posedge ref_clk);
    dbg_conn_req <= 1'b1;
    do @(posedge ref_clk); while (conn_accept !== 1'b1 && conn_reject !== 1'b1 && ++n < 30);
    acc = conn_accept;
    rej = conn_reject;
    dbg_conn_req <= 1'b0;
    n = 0;
    do @(posedge ref_clk); while ((conn_accept !== 1'b0 || conn_reject !== 1'b0) && ++n < 30);
    // released bus no longer holds the old value
    dbg_id      <= ~id;
    dbg_factory <= ~fac;
  endtask
endmodule

// ==== testbench/flash_window_and_debug_id_guard_bench.sv ====
/*
  Self-checking bench for the flash window and debug id guard.
  Assumes the design files and the tool model are compiled before it.
*/
`timescale 1ns/1ns
`include "fwg_defines.svh"
module flash_window_and_debug_id_guard_bench import fwg_pkg::*;;
  // ======================================================================
  // signals and constants
  logic         ref_clk, rst_n, psel, penable, pwrite, sguard_en, op_req;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic         pready, pslverr, op_grant, op_deny, conn_accept, conn_reject, flash_erase_req;
  logic [5:0]   engine_en;
  logic [15:0]  op_blk;
  logic         dbg_conn_req, dbg_factory;
  logic [127:0] dbg_id;
  int           miscompares, total_checks, erase_seen;
  localparam logic [31:0]  C_SET = 32'h1 << `FWG_CTRL_SET;
  localparam logic [31:0]  C_CLR = 32'h1 << `FWG_CTRL_CLR;
  localparam logic [31:0]  C_LCK = 32'h1 << `FWG_CTRL_LOCK;
  localparam logic [31:0]  C_ERS = 32'h1 << `FWG_CTRL_ERASE;
  localparam logic [127:0] ID_A  = 128'h8123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
  localparam logic [127:0] ID_B  = 128'hc0de_0000_1111_2222_3333_4444_5555_6666;
  localparam logic [127:0] ID_C  = 128'h7fff_ffff_ffff_ffff_ffff_ffff_ffff_ffff;

  // ======================================================================
  // clock, erase pulse counter, instances
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (flash_erase_req === 1'b1) erase_seen <= erase_seen + 1;
  fwg_guard uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_en(engine_en), .sguard_en(sguard_en), .op_req(op_req), .op_blk(op_blk),
    .op_grant(op_grant), .op_deny(op_deny), .dbg_conn_req(dbg_conn_req), .dbg_factory(dbg_factory),
    .dbg_id(dbg_id), .conn_accept(conn_accept), .conn_reject(conn_reject),
    .flash_erase_req(flash_erase_req));
  fwg_tool_model tool (.ref_clk(ref_clk), .conn_accept(conn_accept), .conn_reject(conn_reject),
    .dbg_conn_req(dbg_conn_req), .dbg_factory(dbg_factory), .dbg_id(dbg_id));

  // ======================================================================
  // compare, bus and port tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // request held until pready is sampled high; never assumes a wait count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) miscompares++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, x, q);
  endtask
  task automatic put_id(input logic [127:0] id);
    for (int i = 0; i < 4; i++) wr(`FWG_OFS_ID0 + 8'(4 * i), id[32*i +: 32], 1'b0);
  endtask
  task automatic id_is(input logic [127:0] id);
    for (int i = 0; i < 4; i++) rd("id word", `FWG_OFS_ID0 + 8'(4 * i), id[32*i +: 32]);
  endtask
  // grant or deny is looked at in the one cycle that it stands
  task automatic op(input logic [15:0] b, input logic g);
    @(posedge ref_clk);
    op_req <= 1'b1;
    op_blk <= b;
    @(posedge ref_clk);
    op_req <= 1'b0;
    #1;
    chk("op_grant", {31'h0, g}, {31'h0, op_grant});
    chk("op_deny", {31'h0, ~g}, {31'h0, op_deny});
  endtask
  task automatic conn(input logic [127:0] id, input logic f, input int lag, input logic ea, input int ee);
    int e0;
    logic a, r;
    e0 = erase_seen;
    tool.connect(id, f, lag, a, r);
    chk("conn_accept", {31'h0, ea}, {31'h0, a});
    chk("conn_reject", {31'h0, ~ea}, {31'h0, r});
    chk("erase pulses", 32'(ee), 32'(erase_seen - e0));
    chk("released", 32'h0, {30'h0, conn_accept, conn_reject});
  endtask

  // ======================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd("status", `FWG_OFS_STATUS, 32'h1);
    rd("win start", `FWG_OFS_WIN_START, 32'h0);
    id_is(`FWG_ID_ERASED);
    op(16'hbeef, 1'b1);
    apb(1'b0, 8'h3c, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic t_window;
    wr(`FWG_OFS_STG_START, 32'h4, 1'b0);
    wr(`FWG_OFS_STG_END, 32'h8, 1'b0);
    wr(`FWG_OFS_CTRL, C_SET, 1'b0);
    rd("win end", `FWG_OFS_WIN_END, 32'h8);
    op(16'h3, 1'b0);
    op(16'h4, 1'b1);
    op(16'h7, 1'b1);
    op(16'h8, 1'b0);
  endtask
  // every engine alone must block config writes
  task automatic t_busy;
    wr(`FWG_OFS_STG_START, 32'h1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      engine_en <= 6'h1 << i;
      wr(`FWG_OFS_CTRL, C_SET, 1'b1);
    end
    wr(`FWG_OFS_ID0, 32'h0, 1'b1);
    engine_en <= 6'h0;
    rd("win start", `FWG_OFS_WIN_START, 32'h4);
    rd("status", `FWG_OFS_STATUS, 32'h5);
    wr(`FWG_OFS_STATUS, 32'h1c, 1'b0);
    wr(`FWG_OFS_CTRL, C_CLR | C_SET, 1'b0);
    rd("win end", `FWG_OFS_WIN_END, 32'h0);
    op(16'h0, 1'b1);
  endtask
  task automatic t_ids;
    put_id(ID_A);
    conn(ID_A, 1'b0, 0, 1'b1, 0);
    conn(ID_A, 1'b1, 3, 1'b1, 0);
    conn(ID_A ^ 128'h1, 1'b0, 0, 1'b0, 0);
    conn(ID_A ^ (128'h1 << 125), 1'b1, 0, 1'b0, 0);
    put_id(ID_C);
    conn(ID_C, 1'b0, 0, 1'b0, 0);
    conn(ID_C, 1'b1, 0, 1'b0, 0);
    put_id(ID_B);
    sguard_en <= 1'b1;
    conn(ID_B, 1'b1, 0, 1'b0, 0);
    conn(ID_B, 1'b0, 0, 1'b1, 0);
    sguard_en <= 1'b0;
    conn(ID_B, 1'b1, 2, 1'b1, 1);
    id_is(`FWG_ID_ERASED);
    put_id(ID_A);
    wr(`FWG_OFS_CTRL, C_ERS, 1'b0);
    id_is(`FWG_ID_ERASED);
  endtask
  task automatic t_lock;
    put_id(ID_B);
    wr(`FWG_OFS_STG_START, 32'h2, 1'b0);
    wr(`FWG_OFS_STG_END, 32'h5, 1'b0);
    wr(`FWG_OFS_CTRL, C_SET | C_LCK, 1'b0);
    wr(`FWG_OFS_STATUS, 32'h1c, 1'b0);
    rd("status", `FWG_OFS_STATUS, 32'h0);
    wr(`FWG_OFS_STG_START, 32'h9, 1'b0);
    wr(`FWG_OFS_CTRL, C_SET, 1'b0);
    wr(`FWG_OFS_CTRL, C_CLR, 1'b0);
    wr(`FWG_OFS_CTRL, C_ERS, 1'b0);
    rd("win start", `FWG_OFS_WIN_START, 32'h2);
    rd("win end", `FWG_OFS_WIN_END, 32'h5);
    rd("status", `FWG_OFS_STATUS, 32'h4);
    op(16'h1, 1'b0);
    op(16'h5, 1'b0);
    op(16'h2, 1'b1);
    conn(ID_B, 1'b1, 0, 1'b1, 0);
    id_is(ID_B);
    rd("status", `FWG_OFS_STATUS, 32'hc);
  endtask

  // ======================================================================
  // a second reset restores the volatile lock, window and id code
  task automatic t_rerun;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
  endtask

  // ======================================================================
  // verdict, watchdog and main sequence
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
  initial begin
    {ref_clk, rst_n, psel, penable, pwrite, sguard_en, op_req} = 7'h0;
    {paddr, pwdata, engine_en, op_blk} = 62'h0;
    {miscompares, total_checks, erase_seen} = 96'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_window;
    t_busy;
    t_ids;
    t_lock;
    t_rerun;
    wrap_up;
  end
endmodule
